// ==== hdl/dsw_pkg.sv ====
// register map, field positions, reset values and states of the deep standby wake-up timer
// assumes a byte-wide register port with 24-bit addresses
package dsw_pkg;

	// register addresses
	localparam logic [23:0] ADDR_TIMER_CTRL  = 24'hff_fabc;
	localparam logic [23:0] ADDR_CNT_LO      = 24'hff_fab4;
	localparam logic [23:0] ADDR_CNT_MID     = 24'hff_fab5;
	localparam logic [23:0] ADDR_CNT_HI      = 24'hff_fab6;
	localparam logic [23:0] ADDR_WAKE_ENABLE = 24'hff_fe72;
	localparam logic [23:0] ADDR_WAKE_FLAGS  = 24'hff_fe73;
	localparam logic [23:0] ADDR_EDGE_SELECT = 24'hff_fe74;
	localparam logic [23:0] ADDR_IRQ_STATUS  = 24'hff_fe76;
	localparam logic [23:0] ADDR_IRQ_MASK    = 24'hff_fe77;

	// wake source bit positions, shared by enable, flag, status and mask; edge select uses all but the timer bit
	localparam int BIT_NMI   = 7;
	localparam int BIT_TIMER = 5;
	localparam int BIT_REQ3  = 3;
	localparam int BIT_REQ0  = 0;
	localparam logic [7:0] SRC_MASK  = 8'h00af;
	localparam logic [7:0] EDGE_MASK = 8'h008f;

	// timer control fields
	localparam int BIT_EXT_CLK = 7;
	localparam int BIT_RUN     = 5;
	localparam int CKS_HI      = 1;
	localparam int CKS_LO      = 0;
	localparam logic [1:0] CKS_DIV_32768 = 2'h1;
	localparam logic [7:0] CTRL_MASK     = 8'h00a3;

	// subclock prescale and counter width
	localparam int SUB_DIV   = 32768;
	localparam int CNT_WIDTH = 24;

	// reset values
	localparam logic [7:0] RST_CTRL   = 8'h0000;
	localparam logic [7:0] RST_ENABLE = 8'h0000;
	localparam logic [7:0] RST_FLAGS  = 8'h0000;
	localparam logic [7:0] RST_EDGE   = 8'h0000;
	localparam logic [7:0] RST_MASK   = 8'h0000;

	// standby state
	typedef enum logic [0:0]
	{
		DSW_ST_RUN  = 1'b0,
		DSW_ST_DEEP = 1'b1
	} dsw_state_e;

endpackage

// ==== hdl/dsw_edge_if.sv ====
// per-pin link between the wake controller and one edge detector
// assumes both ends share core_clk_in
`timescale 1ns/10ps
interface dsw_edge_if;
	logic edge_rising;
	logic hit;

	modport ctrl
	(
		output edge_rising,
		input  hit
	);
	modport det
	(
		input  edge_rising,
		output hit
	);
endinterface

// ==== hdl/dsw_edge_detect.sv ====
// synchroniser and selectable edge detector for one asynchronous pin
// assumes the pin is asynchronous to core_clk_in
`timescale 1ns/10ps
module dsw_edge_detect
(
	// clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_b_in,
	// pin and control link
	input  wire logic pin_in,
	dsw_edge_if.det   link
);

	logic [2:0] sync_q;
	logic [2:0] sync_d;
	logic       hit_q;
	logic       hit_d;

	// two-stage synchroniser, third stage holds the previous level
	always_comb
	begin
		sync_d = {sync_q[1:0], pin_in};
		hit_d  = link.edge_rising ? (sync_q[1] & ~sync_q[2]) : (~sync_q[1] & sync_q[2]);
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sync_q <= 3'h7;
			hit_q  <= 1'b0;
		end
		else
		begin
			sync_q <= sync_d;
			hit_q  <= hit_d;
		end
	end

	assign link.hit = hit_q;

	chk_fall_edge_hit : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(!link.edge_rising && !sync_q[1] && sync_q[2]) |=> hit_q)
		else $error("falling edge did not raise hit");
	chk_rise_edge_hit : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(link.edge_rising && sync_q[1] && !sync_q[2]) |=> hit_q)
		else $error("rising edge did not raise hit");

endmodule // dsw_edge_detect

// ==== hdl/dsw_wakeup_timer.sv ====
// deep standby wake-up control with long-interval subclock timer and register port
// assumes a byte register port on core_clk_in; pins and subclock are asynchronous
`timescale 1ns/10ps
module dsw_wakeup_timer #(
	parameter int CNT_W = dsw_pkg::CNT_WIDTH,
	parameter int DIV   = dsw_pkg::SUB_DIV
)
(
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_b_in,
	// register port
	input  wire logic [23:0] addr_in,
	input  wire logic [7:0]  wr_data_in,
	input  wire logic        wr_en_in,
	input  wire logic        rd_en_in,
	output logic      [7:0]  rd_data_out,
	// wake pins and subclock
	input  wire logic        nmi_pin_in,
	input  wire logic [3:0]  req_pin_in,
	input  wire logic        sub_clock_in,
	// sleep control from the cpu
	input  wire logic        sleep_exec_in,
	input  wire logic        standby_select_in,
	input  wire logic        deep_standby_select_in,
	input  wire logic        standby_clear_pending_in,
	// status outputs
	output logic             deep_standby_out,
	output logic             wake_out,
	output logic             irq_out
);

	localparam int PRE_W = $clog2(DIV);

	dsw_edge_if edge_link [6] ();
	logic [5:0] pin_vec;
	logic [7:0] ctrl_q, ctrl_d, enable_q, enable_d, edge_q, edge_d;
	logic [7:0] flags_q, flags_d, armed_q, armed_d, status_q, status_d, mask_q, mask_d;
	logic [7:0] rd_data_q, rd_data_d, events;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [PRE_W-1:0] pre_q, pre_d;
	logic [23:0]      cnt_rd;
	logic       tick, ovf, sub_rise, run, wake_q, wake_d;
	dsw_pkg::dsw_state_e state_q, state_d;

	// pin order: req0..req3, nmi, subclock
	assign pin_vec = {sub_clock_in, nmi_pin_in, req_pin_in};

	// one synchroniser and edge detector per pin
	for (genvar g = 0; g < 6; g++)
	begin : g_pin
		dsw_edge_detect u_edge
		(
			.core_clk_in (core_clk_in),
			.rst_b_in    (rst_b_in),
			.pin_in      (pin_vec[g]),
			.link        (edge_link[g])
		);
	end
	for (genvar g = 0; g < 4; g++)
	begin : g_req_sel
		assign edge_link[g].edge_rising = edge_q[dsw_pkg::BIT_REQ0 + g];
	end
	assign edge_link[4].edge_rising = edge_q[dsw_pkg::BIT_NMI];
	assign edge_link[5].edge_rising = 1'b1;
	assign sub_rise = edge_link[5].hit;

	// prescaler and long-interval counter
	always_comb
	begin
		run   = ctrl_q[dsw_pkg::BIT_RUN];
		tick  = 1'b0;
		pre_d = pre_q;
		cnt_d = cnt_q;
		if (!run)
		begin
			pre_d = '0;
			cnt_d = '0;
		end
		else if (!ctrl_q[dsw_pkg::BIT_EXT_CLK] &&
			ctrl_q[dsw_pkg::CKS_HI:dsw_pkg::CKS_LO] == dsw_pkg::CKS_DIV_32768 && sub_rise)
		begin
			tick  = (pre_q == PRE_W'(DIV - 1));
			pre_d = tick ? '0 : PRE_W'(pre_q + 1'b1); // wraps at DIV, power of two or not
			if (tick)
				cnt_d = cnt_q + 1'b1;
		end
		ovf = tick && (&cnt_q);
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pre_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
		end
	end

	// wake events in register layout
	always_comb
	begin
		events = 8'h0000;
		events[dsw_pkg::BIT_REQ3:dsw_pkg::BIT_REQ0] =
			{edge_link[3].hit, edge_link[2].hit, edge_link[1].hit, edge_link[0].hit};
		events[dsw_pkg::BIT_NMI]   = edge_link[4].hit;
		events[dsw_pkg::BIT_TIMER] = ovf;
	end

	// counter widened to the three readback bytes; a narrow counter reads zero above its top
	assign cnt_rd = 24'(cnt_q);

	// registers, flags, interrupt status and read data
	always_comb
	begin
		ctrl_d    = ctrl_q;
		enable_d  = enable_q;
		edge_d    = edge_q;
		mask_d    = mask_q;
		flags_d   = flags_q;
		armed_d   = armed_q;
		status_d  = status_q;
		rd_data_d = 8'h0000;
		if (wr_en_in)
		begin
			case (addr_in)
				dsw_pkg::ADDR_TIMER_CTRL:  ctrl_d   = wr_data_in & dsw_pkg::CTRL_MASK;
				dsw_pkg::ADDR_WAKE_ENABLE: enable_d = wr_data_in & dsw_pkg::SRC_MASK;
				dsw_pkg::ADDR_EDGE_SELECT: edge_d   = wr_data_in & dsw_pkg::EDGE_MASK;
				dsw_pkg::ADDR_IRQ_MASK:    mask_d   = wr_data_in & dsw_pkg::SRC_MASK;
				dsw_pkg::ADDR_IRQ_STATUS:  status_d = status_q & ~wr_data_in;
				dsw_pkg::ADDR_WAKE_FLAGS:
				begin
					flags_d = flags_q & ~(armed_q & ~wr_data_in);
					armed_d = 8'h0000;
				end
				default: ;
			endcase
		end
		if (rd_en_in)
		begin
			case (addr_in)
				dsw_pkg::ADDR_TIMER_CTRL:  rd_data_d = ctrl_q;
				dsw_pkg::ADDR_CNT_LO:      rd_data_d = cnt_rd[7:0];
				dsw_pkg::ADDR_CNT_MID:     rd_data_d = cnt_rd[15:8];
				dsw_pkg::ADDR_CNT_HI:      rd_data_d = cnt_rd[23:16];
				dsw_pkg::ADDR_WAKE_ENABLE: rd_data_d = enable_q;
				dsw_pkg::ADDR_EDGE_SELECT: rd_data_d = edge_q;
				dsw_pkg::ADDR_IRQ_STATUS:  rd_data_d = status_q;
				dsw_pkg::ADDR_IRQ_MASK:    rd_data_d = mask_q;
				dsw_pkg::ADDR_WAKE_FLAGS:
				begin
					rd_data_d = flags_q;
					armed_d   = flags_q;
				end
				default:                   rd_data_d = 8'h0000;
			endcase
		end
		flags_d  = flags_d | events;
		status_d = status_d | events;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ctrl_q    <= dsw_pkg::RST_CTRL;
			enable_q  <= dsw_pkg::RST_ENABLE;
			edge_q    <= dsw_pkg::RST_EDGE;
			mask_q    <= dsw_pkg::RST_MASK;
			flags_q   <= dsw_pkg::RST_FLAGS;
			armed_q   <= 8'h0000;
			status_q  <= 8'h0000;
			rd_data_q <= 8'h0000;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			enable_q  <= enable_d;
			edge_q    <= edge_d;
			mask_q    <= mask_d;
			flags_q   <= flags_d;
			armed_q   <= armed_d;
			status_q  <= status_d;
			rd_data_q <= rd_data_d;
		end
	end

	// deep standby entry and exit; standby select is owned by the cpu
	always_comb
	begin
		state_d = state_q;
		wake_d  = 1'b0;
		case (state_q)
			dsw_pkg::DSW_ST_RUN:
				if (sleep_exec_in && standby_select_in && deep_standby_select_in &&
					!standby_clear_pending_in)
					state_d = dsw_pkg::DSW_ST_DEEP;
			dsw_pkg::DSW_ST_DEEP:
				if (|(flags_q & enable_q))
				begin
					state_d = dsw_pkg::DSW_ST_RUN;
					wake_d  = 1'b1;
				end
			default: state_d = dsw_pkg::DSW_ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_q <= dsw_pkg::DSW_ST_RUN;
			wake_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wake_q  <= wake_d;
		end
	end

	assign rd_data_out      = rd_data_q;
	assign deep_standby_out = (state_q == dsw_pkg::DSW_ST_DEEP);
	assign wake_out         = wake_q;
	assign irq_out          = |(status_q & mask_q);

	// checks
	sequence s_edge_write;
		wr_en_in && addr_in == dsw_pkg::ADDR_EDGE_SELECT;
	endsequence
	sequence s_edge_read;
		rd_en_in && addr_in == dsw_pkg::ADDR_EDGE_SELECT;
	endsequence
	sequence s_deep_entry;
		state_q == dsw_pkg::DSW_ST_RUN && sleep_exec_in && standby_select_in &&
			deep_standby_select_in && !standby_clear_pending_in;
	endsequence

	chk_edge_reg_readback : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(s_edge_write ##1 s_edge_read) |=> rd_data_out == edge_q)
		else $error("edge select read back wrong");
	chk_timer_wake_exit : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(deep_standby_out && flags_q[dsw_pkg::BIT_TIMER] && enable_q[dsw_pkg::BIT_TIMER])
		|=> !deep_standby_out && wake_out)
		else $error("enabled timer flag did not end deep standby");
	chk_timer_flag_set : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		ovf |=> flags_q[dsw_pkg::BIT_TIMER])
		else $error("timer overflow did not set flag");
	chk_req_flag_set : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		edge_link[1].hit |=> flags_q[1] && status_q[1])
		else $error("request pin 1 edge did not set flag");
	chk_flag_write_guard : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(wr_en_in && addr_in == dsw_pkg::ADDR_WAKE_FLAGS && !armed_q[0] && flags_q[0])
		|=> flags_q[0])
		else $error("unarmed write cleared a flag");
	chk_ctrl_field_mask : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(wr_en_in && addr_in == dsw_pkg::ADDR_TIMER_CTRL) |=>
		ctrl_q == ($past(wr_data_in) & dsw_pkg::CTRL_MASK))
		else $error("timer control write stored wrong fields");
	chk_div_tick : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		tick |-> pre_q == PRE_W'(DIV - 1) && sub_rise)
		else $error("tick not on prescaler wrap");
	chk_run_counts : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(run && tick) |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
		else $error("counter did not advance on tick");
	chk_stop_clears_cnt : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		!run |=> cnt_q == '0 && pre_q == '0)
		else $error("stopped counter not zero");
	chk_deep_entry : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		s_deep_entry |=> deep_standby_out)
		else $error("deep standby not entered");
	chk_armed_flag_clear : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(wr_en_in && addr_in == dsw_pkg::ADDR_WAKE_FLAGS && armed_q[0] && !wr_data_in[0] &&
		!events[0]) |=> !flags_q[0])
		else $error("armed flag not cleared by writing zero");
	chk_req0_flag_set : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		edge_link[0].hit |=> flags_q[0] && status_q[0])
		else $error("request pin 0 edge did not set flag");
	chk_wake_one_cycle : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		wake_out |-> !deep_standby_out ##1 !wake_out)
		else $error("wake pulse not a single cycle out of standby");

endmodule // dsw_wakeup_timer

// ==== verification/dsw_pin_model.sv ====
// far-side model: four request pins, the nmi pin and a gated subclock oscillator
// assumes the bench calls its tasks; pins idle high, subclock idle low between bursts
`timescale 1ns/10ps
module dsw_pin_model
(
	// wake pins
	output logic       nmi_pin_out,
	output logic [3:0] req_pin_out,
	// subclock
	output logic       sub_clock_out
);
	// idle levels from time zero
	initial
	begin
		nmi_pin_out   = 1'b1;
		req_pin_out   = 4'hf;
		sub_clock_out = 1'b0;
	end

	// index 4 is the nmi pin; changes land 1 ns off the clock edge, level held 20 ns
	task automatic set_pin(input int idx, input logic lvl);
		#1;
		if (idx == 4)
			nmi_pin_out = lvl;
		else
			req_pin_out[idx] = lvl;
		#20;
	endtask

	// n subclock cycles of 40 ns, left standing low afterwards
	task automatic tick(input int n);
		#1;
		repeat (n)
		begin
			#20 sub_clock_out = 1'b1;
			#20 sub_clock_out = 1'b0;
		end
	endtask
endmodule // dsw_pin_model

// ==== verification/test_dsw_wakeup_timer.sv ====
// self-checking bench for the deep standby wake-up timer
// assumes a prescale of 4 and an 8-bit counter so a timer overflow fits the run
`timescale 1ns/10ps
module test_dsw_wakeup_timer;
	localparam int CW = 8;
	localparam int DV = 4;
	logic        clk;
	logic        rst_b;
	logic [23:0] addr;
	logic [7:0]  wdat;
	logic        wen;
	logic        ren;
	logic [7:0]  rdat;
	logic        nmi_pin;
	logic [3:0]  req_pin;
	logic        sub_clk;
	logic        sleep;
	logic        ssel;
	logic        dsel;
	logic        pend;
	logic        deep;
	logic        wake;
	logic        irq;
	logic [7:0]  rv;
	int          bad_count;
	int          checks;
	int          cyc;
	int          wakes;

	dsw_pin_model pins
	(
		.nmi_pin_out   (nmi_pin),
		.req_pin_out   (req_pin),
		.sub_clock_out (sub_clk)
	);

	dsw_wakeup_timer #(.CNT_W(CW), .DIV(DV)) uut
	(
		.core_clk_in              (clk),
		.rst_b_in                 (rst_b),
		.addr_in                  (addr),
		.wr_data_in               (wdat),
		.wr_en_in                 (wen),
		.rd_en_in                 (ren),
		.rd_data_out              (rdat),
		.nmi_pin_in               (nmi_pin),
		.req_pin_in               (req_pin),
		.sub_clock_in             (sub_clk),
		.sleep_exec_in            (sleep),
		.standby_select_in        (ssel),
		.deep_standby_select_in   (dsel),
		.standby_clear_pending_in (pend),
		.deep_standby_out         (deep),
		.wake_out                 (wake),
		.irq_out                  (irq)
	);

	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// wake pulse counter and hang limit
	always @(posedge clk)
	begin
		cyc++;
		if (wake === 1'b1)
			wakes++;
		if (cyc == 40000)
		begin
			bad_count++;
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wen  <= 1'b1;
		@(posedge clk);
		wen  <= 1'b0;
		// step past the edge so later checks see the written register
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [23:0] a);
		@(posedge clk);
		addr <= a;
		ren  <= 1'b1;
		@(posedge clk);
		ren  <= 1'b0;
		#1 rv = rdat;
	endtask

	task automatic t_reset;
		logic [23:0] regs [6];
		regs = '{dsw_pkg::ADDR_TIMER_CTRL, dsw_pkg::ADDR_WAKE_ENABLE, dsw_pkg::ADDR_WAKE_FLAGS,
			dsw_pkg::ADDR_EDGE_SELECT, dsw_pkg::ADDR_IRQ_MASK, 24'hff_fe75};
		wr(24'hff_fe75, 8'hff);
		foreach (regs[i])
		begin
			rd(regs[i]);
			chk("reset value", rv, 8'h00);
		end
		wr(dsw_pkg::ADDR_EDGE_SELECT, 8'hff);
		rd(dsw_pkg::ADDR_EDGE_SELECT);
		chk("edge select", rv, dsw_pkg::EDGE_MASK);
		$display("test reset done");
	endtask

	task automatic t_edges;
		wr(dsw_pkg::ADDR_EDGE_SELECT, 8'h00);
		wr(dsw_pkg::ADDR_IRQ_MASK, 8'h01);
		for (int i = 0; i < 5; i++)
		begin
			pins.set_pin(i, 1'b0);
			pins.set_pin(i, 1'b1);
		end
		repeat (4) @(posedge clk);
		chk("irq raised", irq, 8'h01);
		wr(dsw_pkg::ADDR_WAKE_FLAGS, 8'h00);
		rd(dsw_pkg::ADDR_WAKE_FLAGS);
		chk("flags kept", rv, 8'h8f);
		wr(dsw_pkg::ADDR_WAKE_FLAGS, 8'h80);
		rd(dsw_pkg::ADDR_WAKE_FLAGS);
		chk("flags cleared", rv, 8'h80);
		wr(dsw_pkg::ADDR_WAKE_FLAGS, 8'h00);
		wr(dsw_pkg::ADDR_IRQ_MASK, 8'h00);
		chk("irq masked", irq, 8'h00);
		wr(dsw_pkg::ADDR_IRQ_MASK, 8'h01);
		wr(dsw_pkg::ADDR_IRQ_STATUS, 8'h01);
		rd(dsw_pkg::ADDR_IRQ_STATUS);
		chk("status w1c", rv, 8'h8e);
		chk("irq cleared", irq, 8'h00);
		// rising edge on request pin 1 only
		wr(dsw_pkg::ADDR_EDGE_SELECT, 8'h02);
		pins.set_pin(1, 1'b0);
		rd(dsw_pkg::ADDR_WAKE_FLAGS);
		chk("falling ignored", rv, 8'h00);
		pins.set_pin(1, 1'b1);
		repeat (4) @(posedge clk);
		rd(dsw_pkg::ADDR_WAKE_FLAGS);
		chk("rising flag", rv, 8'h02);
		wr(dsw_pkg::ADDR_WAKE_FLAGS, 8'h00);
		$display("test edges done");
	endtask

	task automatic t_timer;
		wr(dsw_pkg::ADDR_TIMER_CTRL, 8'hff);
		rd(dsw_pkg::ADDR_TIMER_CTRL);
		chk("control bits", rv, dsw_pkg::CTRL_MASK);
		wr(dsw_pkg::ADDR_TIMER_CTRL, 8'h21);
		pins.tick(8);
		repeat (8) @(posedge clk);
		rd(dsw_pkg::ADDR_CNT_LO);
		chk("count", rv, 8'(8 / DV));
		wr(dsw_pkg::ADDR_TIMER_CTRL, 8'h01);
		rd(dsw_pkg::ADDR_CNT_LO);
		chk("count cleared", rv, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			wr(dsw_pkg::ADDR_TIMER_CTRL, i == 0 ? 8'h23 : 8'ha1);
			pins.tick(8);
			repeat (8) @(posedge clk);
			rd(dsw_pkg::ADDR_CNT_LO);
			chk("other select", rv, 8'h00);
		end
		wr(dsw_pkg::ADDR_TIMER_CTRL, 8'h00);
		$display("test timer done");
	endtask

	task automatic sleep_pulse;
		@(posedge clk);
		sleep <= 1'b1;
		@(posedge clk);
		sleep <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic t_deep;
		wr(dsw_pkg::ADDR_WAKE_ENABLE, 8'h20);
		ssel <= 1'b1;
		dsel <= 1'b1;
		pend <= 1'b1;
		sleep_pulse();
		chk("pending blocks", deep, 8'h00);
		pend <= 1'b0;
		sleep_pulse();
		chk("deep entered", deep, 8'h01);
		wr(dsw_pkg::ADDR_TIMER_CTRL, 8'h21);
		pins.tick((1 << CW) * DV - 1);
		repeat (8) @(posedge clk);
		chk("before overflow", deep, 8'h01);
		pins.tick(1);
		repeat (8) @(posedge clk);
		chk("woken", deep, 8'h00);
		chk("wake pulses", 8'(wakes), 8'h01);
		rd(dsw_pkg::ADDR_WAKE_FLAGS);
		chk("timer flag", rv, 8'h20);
		rd(dsw_pkg::ADDR_CNT_LO);
		chk("wrapped", rv, 8'h00);
		// software clears standby select itself after the wake
		ssel <= 1'b0;
		$display("test deep standby done");
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// reset, then the scenarios in order
	initial
	begin
		bad_count = 0;
		checks    = 0;
		cyc       = 0;
		wakes     = 0;
		rst_b     = 1'b0;
		addr      = 24'h00_0000;
		wdat      = 8'h00;
		wen       = 1'b0;
		ren       = 1'b0;
		sleep     = 1'b0;
		ssel      = 1'b0;
		dsel      = 1'b0;
		pend      = 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_edges();
		t_timer();
		t_deep();
		end_sim();
	end
endmodule // test_dsw_wakeup_timer
